/* core/pllcfg_pkg.sv */
package pllcfg_pkg;
    localparam int unsigned ADDR_W = 12;
    // Offsets printed for the revision registers
    localparam logic [11:0] OFF_CM_REV = 12'h3BC;
    localparam logic [11:0] OFF_GP_REV = 12'h3C0;
    localparam logic [11:0] OFF_LS_REV = 12'h3C4;
    // Control and status register offsets
    localparam logic [11:0] OFF_LOOP_CTRL = 12'h300;
    localparam logic [11:0] OFF_FINE_CTRL = 12'h304;
    localparam logic [11:0] OFF_FRAC_CTRL = 12'h308;
    localparam logic [11:0] OFF_FRAC_MUL = 12'h30C;
    localparam logic [11:0] OFF_FRAC_DIV = 12'h310;
    localparam logic [11:0] OFF_LOOP_STAT = 12'h314;
    // Field layouts and write masks of the control registers
    localparam int unsigned LC_EN_BIT = 0;
    localparam int unsigned LC_REF_LSB = 1;
    localparam int unsigned LC_OPT_LSB = 3;
    localparam int unsigned LC_DIV_LSB = 8;
    localparam int unsigned LC_MUL_LSB = 16;
    localparam int unsigned LC_CNT_LSB = 24;
    localparam logic [31:0] LC_WMASK = 32'h3F0F0F3F;
    localparam int unsigned FINE_CNT_LSB = 8;
    localparam int unsigned SEL_LSB = 1;
    localparam logic [31:0] FINE_WMASK = 32'hFFFFFF0F;
    localparam logic [31:0] FRAC_WMASK = 32'h0000000F;
    localparam logic [31:0] FACT_WMASK = 32'h0000FFFF;
    localparam logic [31:0] RESET_VAL = 32'h00000000;
    // Revision words: arbitrary values, no meaning
    localparam logic [11:0] CM_VERSION = 12'h101;
    localparam logic [11:0] GP_VERSION = 12'h102;
    localparam logic [11:0] LS_VERSION = 12'h103;
    localparam logic [3:0] REV_VARIANT = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [5:0] lock_wait_cycles;
        logic [3:0] mul;
        logic [3:0] div;
        logic [2:0] loop_option_bits;
        logic [1:0] loop_reference_select;
        logic loop_synth_enable;
    } pllcfg_loop_t;

    typedef struct packed {
        logic vco_high_band;
        logic out_halved;
        logic wide_bw_on;
        logic [1:0] ref_sel;
        logic enable;
    } pllcfg_core_t;

    function automatic logic [31:0] pllcfg_rev(input logic [11:0] v);
        pllcfg_rev = {12'h000, REV_VARIANT, 4'h0, v};
    endfunction : pllcfg_rev
endpackage : pllcfg_pkg

/* core/pllcfg_top.sv */
// Notes on behaviour
// - Option bit 0 picks VCO band: 0 low 80-180 MHz, 1 high 160-240.
// - Option bit 1 set halves VCO output, clear passes it directly.
// - Option bit 2 clear enables wide bandwidth mode; set disables it.
// - Reference select field picks the clock source feeding the loop.
// - Enable bit powers loop; writes to loop control discarded while on.
// - Fine prescaler counts input periods to 24-bit count, then edges.
// - Fine count may be rewritten while running to retune output.
// - Fine control bit 0 enables prescaler; select field sits above.
// - Fraction control bit 0 enables fractional prescaler.
// - Multiply factor is bits 15:0, updatable while running.
// - Divide factor is bits 15:0, updatable while running.
// - Revision registers read-only: version 11:0, variant 19:16.
// - Lock flag sets on the RC rising edge after the programmed count of RC cycles following write.
//
// The implementer's own choice: the AXI4-Lite register port.
module pllcfg_top
    import pllcfg_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, low
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic system_rc_clock, // RC clock, sampled level
    input wire logic fine_clk_in, // Selected fine prescaler input
    input wire logic frac_clk_in, // Selected fraction prescaler input
    output pllcfg_core_t loop_core_cfg, // Settings to analog loop
    output logic [3:0] loop_mul, // Multiply field to analog loop
    output logic [3:0] loop_div, // Divide field to analog loop
    output logic [1:0] fine_sel, // Fine input select
    output logic [1:0] frac_sel, // Fraction input select
    output logic fine_prescaled_clock, // Fine prescaler output
    output logic fraction_prescaled_clock, // Fraction prescaler output
    output logic lock_status_flag // Loop lock flag
);
    pllcfg_loop_t loop_q;
    logic [31:0] fine_q, frac_q, fmul_q, fdiv_q;
    logic [11:0] awaddr_q, araddr_q;
    logic aw_have_q, w_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic do_write, rc_q, rc_rise;
    logic [5:0] lock_cnt_q;
    logic lock_run_q, lock_q;
    logic [23:0] fine_cnt_q;
    logic fine_out_q;
    logic [16:0] acc_q;
    logic frac_in_q, frac_out_q, fine_in_q;
    logic [31:0] loop_word, wmerge;

    assign loop_word = {2'b00, loop_q.lock_wait_cycles, 4'h0, loop_q.mul,
        4'h0, loop_q.div, 2'b00, loop_q.loop_option_bits,
        loop_q.loop_reference_select, loop_q.loop_synth_enable};

    // Bus: address and data taken in either order, held until the response
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_comb begin
        wmerge = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            wmerge[i*8 +: 8] = wstrb_q[i] ? wdata_q[i*8 +: 8] : 8'h00;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] st, input logic [31:0] m);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r & m;
    endfunction : merge

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            case (awaddr_q & 12'hFFC)
                OFF_LOOP_CTRL, OFF_FINE_CTRL, OFF_FRAC_CTRL,
                OFF_FRAC_MUL, OFF_FRAC_DIV: bresp_q <= RESP_OKAY;
                default: bresp_q <= RESP_SLVERR;
            endcase
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Register writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_q <= '0;
            fine_q <= RESET_VAL;
            frac_q <= RESET_VAL;
            fmul_q <= RESET_VAL;
            fdiv_q <= RESET_VAL;
        end else if (do_write) begin
            case (awaddr_q & 12'hFFC)
                OFF_LOOP_CTRL: begin
                    if (!loop_q.loop_synth_enable) begin
                        loop_q <= pllcfg_loop_t'({wmerge[29:24],
                            wmerge[19:16], wmerge[11:8], wmerge[5:0]});
                    end
                end
                OFF_FINE_CTRL: fine_q <= merge(fine_q, wdata_q, wstrb_q,
                    FINE_WMASK);
                OFF_FRAC_CTRL: frac_q <= merge(frac_q, wdata_q, wstrb_q,
                    FRAC_WMASK);
                OFF_FRAC_MUL: fmul_q <= merge(fmul_q, wdata_q, wstrb_q,
                    FACT_WMASK);
                OFF_FRAC_DIV: fdiv_q <= merge(fdiv_q, wdata_q, wstrb_q,
                    FACT_WMASK);
                default: ;
            endcase
        end
    end

    // Reads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            case (s_axi_araddr & 12'hFFC)
                OFF_LOOP_CTRL: rdata_q <= loop_word & LC_WMASK;
                OFF_FINE_CTRL: rdata_q <= fine_q;
                OFF_FRAC_CTRL: rdata_q <= frac_q;
                OFF_FRAC_MUL: rdata_q <= fmul_q;
                OFF_FRAC_DIV: rdata_q <= fdiv_q;
                OFF_LOOP_STAT: rdata_q <= {31'h0, lock_q};
                OFF_CM_REV: rdata_q <= pllcfg_rev(CM_VERSION);
                OFF_GP_REV: rdata_q <= pllcfg_rev(GP_VERSION);
                OFF_LS_REV: rdata_q <= pllcfg_rev(LS_VERSION);
                default: begin
                    rdata_q <= 32'h00000000;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Loop settings to the analog core
    always_comb begin
        loop_core_cfg.vco_high_band = loop_q.loop_option_bits[0];
        loop_core_cfg.out_halved = loop_q.loop_option_bits[1];
        loop_core_cfg.wide_bw_on = !loop_q.loop_option_bits[2];
        loop_core_cfg.ref_sel = loop_q.loop_reference_select;
        loop_core_cfg.enable = loop_q.loop_synth_enable;
    end
    assign loop_mul = loop_q.mul;
    assign loop_div = loop_q.div;
    assign fine_sel = fine_q[SEL_LSB +: 2];
    assign frac_sel = frac_q[SEL_LSB +: 2];

    // Lock wait counted in RC clock rising edges
    assign rc_rise = system_rc_clock && !rc_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rc_q <= 1'b0;
            lock_run_q <= 1'b0;
            lock_cnt_q <= 6'h00;
            lock_q <= 1'b0;
        end else begin
            rc_q <= system_rc_clock;
            if (do_write && (awaddr_q & 12'hFFC) == OFF_LOOP_CTRL
                && !loop_q.loop_synth_enable) begin
                lock_run_q <= 1'b1;
                lock_cnt_q <= 6'h00;
                lock_q <= 1'b0;
            end else if (lock_run_q && rc_rise) begin
                if (lock_cnt_q >= loop_q.lock_wait_cycles) begin
                    lock_q <= loop_q.loop_synth_enable;
                    lock_run_q <= 1'b0;
                end else begin
                    lock_cnt_q <= lock_cnt_q + 6'h01;
                end
            end
        end
    end
    assign lock_status_flag = lock_q;

    // Fine prescaler: toggle after counting input rising edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fine_in_q <= 1'b0;
            fine_cnt_q <= 24'h000000;
            fine_out_q <= 1'b0;
        end else begin
            fine_in_q <= fine_clk_in;
            if (!fine_q[0]) begin
                fine_cnt_q <= 24'h000000;
                fine_out_q <= 1'b0;
            end else if (fine_clk_in && !fine_in_q) begin
                if (fine_cnt_q >= fine_q[31:8]) begin
                    fine_cnt_q <= 24'h000000;
                    fine_out_q <= !fine_out_q;
                end else begin
                    fine_cnt_q <= fine_cnt_q + 24'h000001;
                end
            end
        end
    end
    assign fine_prescaled_clock = fine_out_q;

    // Fraction prescaler: accumulator toggles output on each overflow
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frac_in_q <= 1'b0;
            acc_q <= 17'h00000;
            frac_out_q <= 1'b0;
        end else begin
            frac_in_q <= frac_clk_in;
            if (!frac_q[0]) begin
                acc_q <= 17'h00000;
                frac_out_q <= 1'b0;
            end else if (frac_clk_in && !frac_in_q) begin
                if (acc_q + {1'b0, fmul_q[15:0]} >= {1'b0, fdiv_q[15:0]})
                begin
                    acc_q <= acc_q + {1'b0, fmul_q[15:0]}
                        - {1'b0, fdiv_q[15:0]};
                    frac_out_q <= !frac_out_q;
                end else begin
                    acc_q <= acc_q + {1'b0, fmul_q[15:0]};
                end
            end
        end
    end
    assign fraction_prescaled_clock = frac_out_q;

    // Steps of a loop control write and of the lock wait
    sequence loop_write_s;
        do_write && (awaddr_q & 12'hFFC) == OFF_LOOP_CTRL;
    endsequence
    sequence lock_wait_done_s;
        lock_run_q && rc_rise && lock_cnt_q >= loop_q.lock_wait_cycles
            && !(do_write && (awaddr_q & 12'hFFC) == OFF_LOOP_CTRL);
    endsequence

    chk_loop_write_lock: assert property (
        @(posedge aclk) disable iff (!aresetn)
        loop_write_s ##0 loop_q.loop_synth_enable |=> $stable(loop_q))
        else $error("loop control changed while enabled");
    chk_wide_bw_sense: assert property (
        @(posedge aclk) disable iff (!aresetn)
        loop_core_cfg.wide_bw_on != loop_q.loop_option_bits[2])
        else $error("wide bandwidth sense wrong");
    chk_lock_after_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        loop_write_s ##0 !loop_q.loop_synth_enable |=> !lock_q)
        else $error("lock flag not cleared on write");
    chk_lock_sets: assert property (
        @(posedge aclk) disable iff (!aresetn)
        lock_wait_done_s |=> lock_q == loop_q.loop_synth_enable)
        else $error("lock flag not set after wait");
    chk_fine_off_idle: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !fine_q[0] |=> !fine_out_q)
        else $error("fine output active while disabled");
    chk_fine_toggle: assert property (
        @(posedge aclk) disable iff (!aresetn)
        fine_q[0] && fine_clk_in && !fine_in_q
        && fine_cnt_q >= fine_q[31:8] |=> fine_out_q != $past(fine_out_q))
        else $error("fine output missed its edge");
    chk_frac_off_idle: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !frac_q[0] |=> !frac_out_q && acc_q == 17'h00000)
        else $error("fraction prescaler active while disabled");
    chk_frac_toggle: assert property (
        @(posedge aclk) disable iff (!aresetn)
        frac_q[0] && frac_clk_in && !frac_in_q
        && acc_q + {1'b0, fmul_q[15:0]} >= {1'b0, fdiv_q[15:0]}
        |=> frac_out_q != $past(frac_out_q))
        else $error("fraction output missed its edge");
    // A divide factor lowered at the next edge may leave the sum above it
    chk_frac_acc_bound: assert property (
        @(posedge aclk) disable iff (!aresetn)
        fmul_q[15:0] < fdiv_q[15:0] && acc_q < {1'b0, fdiv_q[15:0]}
        && $stable(fdiv_q)
        |=> $changed(fdiv_q) || acc_q < {1'b0, fdiv_q[15:0]})
        else $error("fraction accumulator out of range");
    // A count lowered at the next edge may leave the counter above it
    chk_fine_cnt_bound: assert property (
        @(posedge aclk) disable iff (!aresetn)
        fine_q[0] && fine_cnt_q <= fine_q[31:8] && $stable(fine_q)
        |=> $changed(fine_q) || fine_cnt_q <= fine_q[31:8])
        else $error("fine counter passed its limit");
    chk_rev_read: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready
        && (s_axi_araddr & 12'hFFC) == OFF_LS_REV
        |=> rdata_q[31:20] == 12'h000 && rdata_q[15:12] == 4'h0)
        else $error("revision reserved bits not zero");
    chk_write_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    chk_read_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not returned");
endmodule : pllcfg_top

/* bench/test_pllcfg_top.sv */
module test_pllcfg_top
    import pllcfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int LIMIT = 20000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [2:0] ins = 3'b000;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, fsel, qsel;
    logic [31:0] rdata;
    pllcfg_core_t cfg;
    logic [3:0] lmul, ldiv;
    logic fout, qout, lock;
    logic fprev = 1'b0, qprev = 1'b0;
    int ftog = 0, qtog = 0, cycles = 0, err_total = 0, n_checks = 0;

    pllcfg_top DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .system_rc_clock(ins[0]),
        .fine_clk_in(ins[1]), .frac_clk_in(ins[2]),
        .loop_core_cfg(cfg), .loop_mul(lmul), .loop_div(ldiv),
        .fine_sel(fsel), .frac_sel(qsel),
        .fine_prescaled_clock(fout),
        .fraction_prescaled_clock(qout),
        .lock_status_flag(lock)
    );

    always #5 aclk = ~aclk;

    // Count output edges of both prescalers
    always @(posedge aclk) begin
        fprev <= fout;
        qprev <= qout;
        if (fprev !== fout) ftog++;
        if (qprev !== qout) qtog++;
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                          input logic [1:0] rexp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk(rdata, exp, "read data");
        chk({30'h0, rresp}, {30'h0, rexp}, "read response");
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd_chk

    // Rising edges on one of the slow inputs, then settle time
    task automatic edges(input int sel, input int n);
        repeat (n) begin
            ins[sel] <= 1'b1;
            repeat (2) @(posedge aclk);
            ins[sel] <= 1'b0;
            repeat (2) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
    endtask : edges

    task automatic t_reset();
        chk({26'h0, cfg}, 32'h00000008, "cfg after reset");
        chk({25'h0, fsel, qsel, fout, qout, lock}, 32'h0, "outs");
        for (int i = 0; i < 6; i++) rd_chk(OFF_LOOP_CTRL + 12'(4 * i),
            RESET_VAL, RESP_OKAY);
        rd_chk(OFF_CM_REV, {12'h0, REV_VARIANT, 4'h0, CM_VERSION},
            RESP_OKAY);
        rd_chk(OFF_GP_REV, {12'h0, REV_VARIANT, 4'h0, GP_VERSION},
            RESP_OKAY);
        rd_chk(OFF_LS_REV, {12'h0, REV_VARIANT, 4'h0, LS_VERSION},
            RESP_OKAY);
    endtask : t_reset

    task automatic t_fine();
        logic [1:0] r;
        int t0;
        wr(OFF_FINE_CTRL, 32'h00000205, 4'hF, r);
        rd_chk(OFF_FINE_CTRL, 32'h00000205, RESP_OKAY);
        chk({30'h0, fsel}, 32'h2, "fine select");
        t0 = ftog;
        edges(1, 12);
        chk(32'(ftog - t0), 32'd4, "fine edges count 2");
        wr(OFF_FINE_CTRL, 32'h00000005, 4'hF, r);
        t0 = ftog;
        edges(1, 4);
        chk(32'(ftog - t0), 32'd4, "fine edges count 0");
        wr(OFF_FINE_CTRL, 32'h00000004, 4'hF, r);
        t0 = ftog;
        edges(1, 4);
        chk(32'(ftog - t0), 32'd0, "fine disabled");
    endtask : t_fine

    task automatic t_frac();
        logic [1:0] r;
        int t0;
        wr(OFF_FRAC_DIV, 32'h00000003, 4'hF, r);
        wr(OFF_FRAC_MUL, 32'hFFFF0001, 4'hF, r);
        rd_chk(OFF_FRAC_MUL, 32'h00000001, RESP_OKAY);
        wr(OFF_FRAC_CTRL, 32'h00000003, 4'hF, r);
        chk({30'h0, qsel}, 32'h1, "frac select");
        t0 = qtog;
        edges(2, 6);
        chk(32'(qtog - t0), 32'd2, "frac 1 over 3");
        wr(OFF_FRAC_MUL, 32'hAAAAAA02, 4'h1, r);
        rd_chk(OFF_FRAC_MUL, 32'h00000002, RESP_OKAY);
        t0 = qtog;
        edges(2, 3);
        chk(32'(qtog - t0), 32'd2, "frac 2 over 3");
        wr(OFF_FRAC_DIV, 32'h00000004, 4'hF, r);
        t0 = qtog;
        edges(2, 4);
        chk(32'(qtog - t0), 32'd2, "frac 2 over 4");
        wr(OFF_FRAC_CTRL, 32'h00000002, 4'hF, r);
        t0 = qtog;
        edges(2, 3);
        chk(32'(qtog - t0), 32'd0, "frac disabled");
    endtask : t_frac

    task automatic t_unmapped();
        logic [1:0] r;
        wr(12'h200, 32'h12345678, 4'hF, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
        rd_chk(12'h200, 32'h0, RESP_SLVERR);
        wr(OFF_GP_REV, 32'hFFFFFFFF, 4'hF, r);
        rd_chk(OFF_GP_REV, {12'h0, REV_VARIANT, 4'h0, GP_VERSION},
            RESP_OKAY);
    endtask : t_unmapped

    task automatic t_loop();
        logic [1:0] r;
        logic [2:0] o;
        for (int i = 0; i < 8; i++) begin
            o = 3'(i);
            wr(OFF_LOOP_CTRL, {26'h0, o, o[1:0], 1'b0}, 4'hF, r);
            chk({26'h0, cfg}, {26'h0, o[0], o[1], ~o[2], o[1:0], 1'b0},
                "loop options");
        end
        wr(OFF_LOOP_CTRL, 32'h02050301, 4'hF, r);
        chk({20'h0, lmul, ldiv, 3'h0, cfg.enable},
            {20'h0, 4'h5, 4'h3, 3'h0, 1'b1}, "loop on");
        edges(0, 2);
        chk({31'h0, lock}, 32'h0, "lock early");
        edges(0, 1);
        chk({31'h0, lock}, 32'h1, "lock set");
        rd_chk(OFF_LOOP_STAT, 32'h1, RESP_OKAY);
        wr(OFF_LOOP_CTRL, 32'h00000000, 4'hF, r);
        chk({30'h0, r}, {30'h0, RESP_OKAY}, "discard response");
        rd_chk(OFF_LOOP_CTRL, 32'h02050301, RESP_OKAY);
        chk({26'h0, cfg}, 32'h00000009, "loop kept");
    endtask : t_loop

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_fine();
        t_frac();
        t_unmapped();
        t_loop();
        stop_test();
    end
endmodule : test_pllcfg_top
